// *** irq_pkg.sv ***
// Purpose: shared constants for the interrupt controller
// Assumes: 32-bit axi4-lite register bus, byte addresses
// Notes: vector, stack and pc sizes are plain defaults
package irq_pkg;
	localparam int ADDR_W = 8;
	localparam int PC_W = 13;
	localparam int STACK_DEPTH = 6;
	localparam int DEPTH_W = 3;
	localparam int NSRC = 9;
	localparam int SEL_W = 4;
	// source index doubles as priority, lowest index wins
	localparam int SRC_EXT0 = 0;
	localparam int SRC_COMP = 1;
	localparam int SRC_GRP0 = 2;
	localparam int SRC_GRP1 = 3;
	localparam int SRC_GRP2 = 4;
	localparam int SRC_ADC = 5;
	localparam int SRC_TB0 = 6;
	localparam int SRC_EXT1 = 7;
	localparam int SRC_TB1 = 8;
	localparam logic [PC_W-1:0] VEC_BASE = 13'h0004;
	localparam logic [PC_W-1:0] VEC_STEP = 13'h0004;
	// register byte offsets
	localparam logic [ADDR_W-1:0] EN_OFS = 8'h00;
	localparam logic [ADDR_W-1:0] FLAG_OFS = 8'h04;
	localparam logic [ADDR_W-1:0] EDGE_OFS = 8'h08;
	localparam logic [ADDR_W-1:0] TBC_OFS = 8'h0c;
	localparam logic [ADDR_W-1:0] GRP0_OFS = 8'h10;
	localparam logic [ADDR_W-1:0] GRP1_OFS = 8'h14;
	localparam logic [ADDR_W-1:0] GRP2_OFS = 8'h18;
	localparam logic [ADDR_W-1:0] STAT_OFS = 8'h1c;
	// group register fields
	localparam int GRP_FLAG_LSB = 4;
	localparam int GRP_EN_LSB = 0;
	// edge select codes
	localparam logic [1:0] EDGE_OFF = 2'h0;
	localparam logic [1:0] EDGE_RISE = 2'h1;
	localparam logic [1:0] EDGE_FALL = 2'h2;
	localparam logic [1:0] EDGE_BOTH = 2'h3;
	// time base control fields and reset
	localparam logic [7:0] TBC_RESET = 8'h37;
	localparam logic [7:0] TBC_RD_MASK = 8'hf7;
	localparam int TBC_ON_BIT = 7;
	localparam int TBC_CK_BIT = 6;
	localparam int TB1_SEL_LSB = 4;
	localparam int TB0_SEL_LSB = 0;
	localparam int TB_CNT_W = 15;
	localparam logic [15:0] TB0_BASE = 16'h0100;
	localparam logic [15:0] TB1_BASE = 16'h1000;
	localparam logic [1:0] SYS_DIV_LAST = 2'h3;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// *** irq_return_stack.sv ***
// Purpose: return address stack in flip-flops
// Assumes: push and pop never arrive together
// Notes: push when full and pop when empty are ignored
`timescale 1ns/1ps
module irq_return_stack (
	input wire logic clk,
	input wire logic resetn,
	input wire logic push,
	input wire logic [irq_pkg::PC_W-1:0] push_data,
	input wire logic pop,
	output logic [irq_pkg::PC_W-1:0] pop_data,
	output logic [irq_pkg::DEPTH_W-1:0] depth,
	output logic full
);
	import irq_pkg::*;
	typedef struct packed {
		logic [STACK_DEPTH-1:0][PC_W-1:0] mem;
		logic [DEPTH_W-1:0] ptr;
	} stack_t;
	stack_t s_reg;
	stack_t s_next;

	assign full = (s_reg.ptr == DEPTH_W'(STACK_DEPTH));
	assign depth = s_reg.ptr;
	assign pop_data = (s_reg.ptr == '0) ? '0 : s_reg.mem[s_reg.ptr - 3'h1];

	always_comb begin
		s_next = s_reg;
		if (push && !full) begin
			s_next.mem[s_reg.ptr] = push_data;
			s_next.ptr = s_reg.ptr + 3'h1;
		end else if (pop && s_reg.ptr != '0) begin
			s_next.ptr = s_reg.ptr - 3'h1;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end
endmodule

// *** irq_timebase.sv ***
// Purpose: time base divider with two overflow pulses
// Assumes: slow_tick is a one-cycle enable from the slow oscillator logic
// Notes: a period change takes effect at the next tick; the shared counter is not restarted
`timescale 1ns/1ps
module irq_timebase (
	input wire logic clk,
	input wire logic resetn,
	input wire logic [7:0] timebase_control_reg,
	input wire logic slow_tick,
	output logic tb0_ovf,
	output logic tb1_ovf
);
	import irq_pkg::*;
	typedef struct packed {
		logic [1:0] div;
		logic [TB_CNT_W-1:0] cnt;
		logic ovf0;
		logic ovf1;
	} tb_t;
	tb_t s_reg;
	tb_t s_next;
	logic tick;
	logic [TB_CNT_W-1:0] mask0;
	logic [TB_CNT_W-1:0] mask1;

	// period is base shifted by the select field, counted in timebase_clock ticks
	assign mask0 = TB_CNT_W'((TB0_BASE << timebase_control_reg[TB0_SEL_LSB +: 3]) - 16'h1);
	assign mask1 = TB_CNT_W'((TB1_BASE << timebase_control_reg[TB1_SEL_LSB +: 2]) - 16'h1);
	assign tick = timebase_control_reg[TBC_CK_BIT] ? (s_reg.div == SYS_DIV_LAST) : slow_tick;
	assign tb0_ovf = s_reg.ovf0;
	assign tb1_ovf = s_reg.ovf1;

	always_comb begin
		s_next = s_reg;
		s_next.div = s_reg.div + 2'h1;
		s_next.ovf0 = 1'b0;
		s_next.ovf1 = 1'b0;
		if (!timebase_control_reg[TBC_ON_BIT]) begin
			s_next.cnt = '0;
		end else if (tick) begin
			s_next.cnt = s_reg.cnt + 15'h1;
			s_next.ovf0 = ((s_reg.cnt & mask0) == mask0);
			s_next.ovf1 = ((s_reg.cnt & mask1) == mask1);
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end
endmodule

// *** irq_controller.sv ***
// Purpose: interrupt controller with flags, enables, vectoring and wake-up
// Assumes: cpu call and return signals are single-cycle pulses on clk
// Notes: pins and comparator output are asynchronous and are synchronised here
`timescale 1ns/1ps
// Operation
// - source events always set their flag
// - disabled flag stays set, no jump
// - global enable low blocks every interrupt
// - push next pc, jump to vector
// - return pops pc and resumes there
// - service clears the global enable
// - blocked requests still latch their flags
// - full stack blocks acknowledge
// - simultaneous requests use fixed priority
// - flag rising wakes from sleep
// - pin edge per select sets flag
// - pin service clears its flag
// - comparator change sets flag, service clears
// - member flag set raises group flag
// - group service clears only group flag
// - conversion end sets flag, service clears
// - time base overflow sets flag, service clears
// - divider ratio from time base control
// - timer1 group register bit layout
// - eeprom lowvolt group register layout
// - edge code off rise fall both
// - time base period ranges by field
module irq_controller (
	input wire logic clk,
	input wire logic resetn,
	input wire logic [irq_pkg::ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [irq_pkg::ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic [1:0] ext_irq_pins,
	input wire logic comparator_out,
	input wire logic conversion_done,
	input wire logic timer0_amatch,
	input wire logic timer0_pmatch,
	input wire logic timer1_amatch,
	input wire logic timer1_pmatch,
	input wire logic eeprom_write_end,
	input wire logic low_voltage_detect,
	input wire logic slow_tick,
	input wire logic cpu_boundary,
	input wire logic [irq_pkg::PC_W-1:0] cpu_next_pc,
	input wire logic cpu_call,
	input wire logic cpu_ret,
	input wire logic cpu_return_from_interrupt,
	input wire logic cpu_sleep,
	output logic vector_jump,
	output logic [irq_pkg::PC_W-1:0] jump_addr,
	output logic resume,
	output logic [irq_pkg::PC_W-1:0] resume_addr,
	output logic wake_up,
	output logic stack_full
);
	import irq_pkg::*;
	typedef struct packed {
		logic gie;
		logic [NSRC-1:0] en;
		logic [NSRC-1:0] fl;
		logic [3:0] edge_sel;
		logic [7:0] timebase_control_reg;
		logic [5:0] m_en;
		logic [5:0] m_fl;
		logic [2:0] sync1;
		logic [2:0] sync2;
		logic [2:0] sync3;
		logic [2:0] lvl;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
		logic jump;
		logic [PC_W-1:0] jaddr;
		logic resume;
		logic [PC_W-1:0] raddr;
		logic wake;
	} ctrl_t;
	ctrl_t s_reg;
	ctrl_t s_next;

	logic wr_en;
	logic rd_en;
	logic take_now;
	logic [SEL_W-1:0] sel;
	logic [NSRC-1:0] pend;
	logic [NSRC-1:0] src_set;
	logic [NSRC-1:0] clr;
	logic [2:0] agree;
	logic [2:0] rise;
	logic [2:0] fall;
	logic [1:0] ext_ev;
	logic [2:0] grp_set;
	logic [5:0] m_set;
	logic [9:0] m10;
	logic [9:0] tmp10;
	logic tb0_ovf;
	logic tb1_ovf;
	logic [PC_W-1:0] pop_data;
	logic [DEPTH_W-1:0] depth;
	logic full;
	logic wr_hit;
	logic rd_hit;

	irq_return_stack u_stack (
		.clk(clk),
		.resetn(resetn),
		.push(take_now || cpu_call),
		.push_data(cpu_next_pc),
		.pop(cpu_ret || cpu_return_from_interrupt),
		.pop_data(pop_data),
		.depth(depth),
		.full(full)
	);

	irq_timebase u_tb (
		.clk(clk),
		.resetn(resetn),
		.timebase_control_reg(s_reg.timebase_control_reg),
		.slow_tick(slow_tick),
		.tb0_ovf(tb0_ovf),
		.tb1_ovf(tb1_ovf)
	);

	// a change counts only once stages two and three agree, filtering one-cycle glitches
	assign agree = ~(s_reg.sync2 ^ s_reg.sync3);
	assign rise = agree & s_reg.sync3 & ~s_reg.lvl;
	assign fall = agree & ~s_reg.sync3 & s_reg.lvl;

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_pin
			logic [1:0] es;
			assign es = s_reg.edge_sel[2*gi +: 2];
			assign ext_ev[gi] = ((es == EDGE_RISE) && rise[gi]) ||
				((es == EDGE_FALL) && fall[gi]) ||
				((es == EDGE_BOTH) && (rise[gi] || fall[gi]));
		end
	endgenerate

	assign m_set = {eeprom_write_end, low_voltage_detect, timer1_amatch, timer1_pmatch,
		timer0_amatch, timer0_pmatch};

	// dense read and write decode; both channels complete together
	assign wr_en = awvalid && wvalid && !s_reg.bvalid;
	assign rd_en = arvalid && !s_reg.rvalid;
	assign awready = wr_en;
	assign wready = wr_en;
	assign arready = rd_en;
	assign bvalid = s_reg.bvalid;
	assign bresp = s_reg.bresp;
	assign rvalid = s_reg.rvalid;
	assign rresp = s_reg.rresp;
	assign rdata = s_reg.rdata;
	assign vector_jump = s_reg.jump;
	assign jump_addr = s_reg.jaddr;
	assign resume = s_reg.resume;
	assign resume_addr = s_reg.raddr;
	assign wake_up = s_reg.wake;
	assign stack_full = full;
	assign m10 = {{2{wstrb[1]}}, {8{wstrb[0]}}};

	assign pend = s_reg.fl & s_reg.en;
	always_comb begin
		sel = '0;
		for (int i = NSRC - 1; i >= 0; i--) begin
			if (pend[i]) begin
				sel = SEL_W'(i);
			end
		end
	end
	// stack full holds off the jump since the return address would be lost
	assign take_now = cpu_boundary && s_reg.gie && !full && (|pend);

	function automatic logic [31:0] grp_rd(input logic [1:0] f, input logic [1:0] e);
		grp_rd = {26'h0, f, 2'h0, e};
	endfunction

	always_comb begin
		s_next = s_reg;
		wr_hit = 1'b0;
		rd_hit = 1'b1;
		tmp10 = '0;
		clr = '0;
		grp_set = '0;
		src_set = '0;
		s_next.jump = 1'b0;
		s_next.resume = 1'b0;
		s_next.sync1 = {comparator_out, ext_irq_pins};
		s_next.sync2 = s_reg.sync1;
		s_next.sync3 = s_reg.sync2;
		s_next.lvl = (s_reg.sync3 & agree) | (s_reg.lvl & ~agree);
		if (wr_en) begin
			wr_hit = 1'b1;
			if (awaddr == EN_OFS) begin
				tmp10 = ({s_reg.en, s_reg.gie} & ~m10) | (wdata[9:0] & m10);
				s_next.gie = tmp10[0];
				s_next.en = tmp10[9:1];
			end else if (awaddr == FLAG_OFS) begin
				tmp10 = ({s_reg.fl, 1'b0} & ~m10) | (wdata[9:0] & m10);
				s_next.fl = tmp10[9:1];
			end else if (awaddr == EDGE_OFS) begin
				if (wstrb[0]) s_next.edge_sel = wdata[3:0];
			end else if (awaddr == TBC_OFS) begin
				if (wstrb[0]) s_next.timebase_control_reg = wdata[7:0] & TBC_RD_MASK;
			end else if (awaddr == GRP0_OFS) begin
				if (wstrb[0]) begin
					s_next.m_fl[1:0] = wdata[GRP_FLAG_LSB +: 2];
					s_next.m_en[1:0] = wdata[GRP_EN_LSB +: 2];
				end
			end else if (awaddr == GRP1_OFS) begin
				if (wstrb[0]) begin
					s_next.m_fl[3:2] = wdata[GRP_FLAG_LSB +: 2];
					s_next.m_en[3:2] = wdata[GRP_EN_LSB +: 2];
				end
			end else if (awaddr == GRP2_OFS) begin
				if (wstrb[0]) begin
					s_next.m_fl[5:4] = wdata[GRP_FLAG_LSB +: 2];
					s_next.m_en[5:4] = wdata[GRP_EN_LSB +: 2];
				end
			end else begin
				wr_hit = 1'b0;
			end
		end
		if (s_reg.bvalid && bready) s_next.bvalid = 1'b0;
		if (wr_en) begin
			s_next.bvalid = 1'b1;
			s_next.bresp = wr_hit ? RESP_OKAY : RESP_SLVERR;
		end
		if (s_reg.rvalid && rready) s_next.rvalid = 1'b0;
		if (rd_en) begin
			s_next.rvalid = 1'b1;
			if (araddr == EN_OFS) begin
				s_next.rdata = {22'h0, s_reg.en, s_reg.gie};
			end else if (araddr == FLAG_OFS) begin
				s_next.rdata = {22'h0, s_reg.fl, 1'b0};
			end else if (araddr == EDGE_OFS) begin
				s_next.rdata = {28'h0, s_reg.edge_sel};
			end else if (araddr == TBC_OFS) begin
				s_next.rdata = {24'h0, s_reg.timebase_control_reg};
			end else if (araddr == GRP0_OFS) begin
				s_next.rdata = grp_rd(s_reg.m_fl[1:0], s_reg.m_en[1:0]);
			end else if (araddr == GRP1_OFS) begin
				s_next.rdata = grp_rd(s_reg.m_fl[3:2], s_reg.m_en[3:2]);
			end else if (araddr == GRP2_OFS) begin
				s_next.rdata = grp_rd(s_reg.m_fl[5:4], s_reg.m_en[5:4]);
			end else if (araddr == STAT_OFS) begin
				s_next.rdata = {23'h0, |pend, 4'h0, full, depth};
			end else begin
				s_next.rdata = '0;
				rd_hit = 1'b0;
			end
			s_next.rresp = rd_hit ? RESP_OKAY : RESP_SLVERR;
		end
		// member flags are set by hardware or by a group register write, never cleared by service
		s_next.m_fl = s_next.m_fl | m_set;
		for (int g = 0; g < 3; g++) begin
			grp_set[g] = |(s_next.m_fl[2*g +: 2] & ~s_reg.m_fl[2*g +: 2]);
		end
		src_set[SRC_EXT0] = ext_ev[0];
		src_set[SRC_EXT1] = ext_ev[1];
		src_set[SRC_COMP] = rise[2] || fall[2];
		src_set[SRC_GRP0] = grp_set[0];
		src_set[SRC_GRP1] = grp_set[1];
		src_set[SRC_GRP2] = grp_set[2];
		src_set[SRC_ADC] = conversion_done;
		src_set[SRC_TB0] = tb0_ovf;
		src_set[SRC_TB1] = tb1_ovf;
		if (take_now) begin
			s_next.gie = 1'b0;
			clr[sel] = 1'b1;
			s_next.jump = 1'b1;
			s_next.jaddr = VEC_BASE + PC_W'(sel) * VEC_STEP;
		end
		// a new event in the clearing cycle survives: set is applied last
		s_next.fl = (s_next.fl & ~clr) | src_set;
		if (cpu_return_from_interrupt || cpu_ret) begin
			s_next.resume = 1'b1;
			s_next.raddr = pop_data;
		end
		// only a 0-to-1 change wakes; a flag set before sleep stays quiet
		s_next.wake = cpu_sleep && ((|(s_next.fl & ~s_reg.fl)) ||
			(|(s_next.m_fl & ~s_reg.m_fl)));
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			s_reg <= '0;
			s_reg.timebase_control_reg <= TBC_RESET;
		end else begin
			s_reg <= s_next;
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!resetn);

	sequence take_s;
		take_now;
	endsequence
	sequence jump_s(logic [SEL_W-1:0] v);
		vector_jump && (jump_addr == VEC_BASE + PC_W'(v) * VEC_STEP);
	endsequence

	flag_set_adc_a: assert property (conversion_done |=> s_reg.fl[SRC_ADC])
		else $error("conversion event did not set its flag");
	flag_hold_a: assert property (s_reg.fl[SRC_TB0] && !s_reg.en[SRC_TB0] && !wr_en
		|=> s_reg.fl[SRC_TB0])
		else $error("disabled flag was lost");
	global_block_a: assert property (!s_reg.gie |-> !take_now)
		else $error("interrupt taken with global enable low");
	vector_jump_a: assert property (take_s |=> jump_s($past(sel)))
		else $error("vector jump missing or wrong address");
	return_pop_a: assert property ((cpu_return_from_interrupt && depth != '0) |=>
		resume && (depth == $past(depth) - 3'h1))
		else $error("return did not pop the stack");
	global_clear_a: assert property (take_s |=> !s_reg.gie)
		else $error("global enable not cleared on service");
	blocked_latch_a: assert property (!s_reg.gie && tb1_ovf |=> s_reg.fl[SRC_TB1])
		else $error("blocked request not recorded");
	stack_full_a: assert property (full |-> !take_now)
		else $error("interrupt taken with stack full");
	priority_pick_a: assert property (take_now |->
		(pend[sel] && ((pend & ((9'h1 << sel) - 9'h1)) == '0)))
		else $error("lower priority vector chosen");
	wake_rise_a: assert property (wake_up |-> $past(cpu_sleep))
		else $error("wake outside sleep");
	ext_clear_a: assert property (take_now && sel == SEL_W'(SRC_EXT0)
		&& !src_set[SRC_EXT0] |=> !s_reg.fl[SRC_EXT0])
		else $error("pin flag not cleared on service");
	member_keep_a: assert property (take_now && sel == SEL_W'(SRC_GRP2) && !wr_en
		|=> (($past(s_reg.m_fl) & ~s_reg.m_fl) == '0))
		else $error("member flag cleared by service");
	group_raise_a: assert property (eeprom_write_end && !s_reg.m_fl[5] && !wr_en
		|=> s_reg.fl[SRC_GRP2])
		else $error("group flag not raised");
endmodule

// *** cpu_seq.sv ***
// Purpose: cpu sequencer model on the far side of the interrupt controller
// Assumes: bench requests are one-cycle pulses, never a call and a return together
// Notes: slow mode offers a boundary every fourth cycle and returns with a plain ret
`timescale 1ns/1ps
module cpu_seq (
	input wire logic clk,
	input wire logic resetn,
	input wire logic slow,
	input wire logic call_req,
	input wire logic ret_req,
	input wire logic sleep_req,
	input wire logic vector_jump,
	output logic cpu_boundary,
	output logic [irq_pkg::PC_W-1:0] cpu_next_pc,
	output logic cpu_call,
	output logic cpu_ret,
	output logic cpu_return_from_interrupt,
	output logic cpu_sleep,
	output logic [irq_pkg::PC_W-1:0] saved_pc
);
	import irq_pkg::*;
	logic [1:0] phase;
	logic [PC_W-1:0] prev_pc;
	logic [PC_W-1:0] stk[$];
	always @(posedge clk) begin
		if (!resetn) begin
			{phase, prev_pc, cpu_next_pc, saved_pc} <= '0;
			{cpu_boundary, cpu_call, cpu_ret, cpu_return_from_interrupt, cpu_sleep} <= '0;
			stk.delete();
		end else begin
			phase <= phase + 2'h1;
			cpu_boundary <= !slow || phase == 2'h3;
			cpu_next_pc <= cpu_next_pc + 13'h3;
			prev_pc <= cpu_next_pc;
			cpu_call <= call_req;
			cpu_ret <= ret_req & slow;
			cpu_return_from_interrupt <= ret_req & !slow;
			cpu_sleep <= sleep_req;
			// a push onto a full stack is lost, so the model drops it too
			if ((vector_jump || cpu_call) && stk.size() < STACK_DEPTH)
				stk.push_back(vector_jump ? prev_pc : cpu_next_pc);
			if (cpu_ret || cpu_return_from_interrupt)
				saved_pc <= (stk.size() > 0) ? stk.pop_back() : '0;
		end
	end
endmodule

// *** tb_top.sv ***
// Purpose: self-checking bench for the interrupt controller
// Assumes: register map, vectors and priority as set in irq_pkg
// Notes: flags are modelled with integers; a cpu model answers on the far side
`timescale 1ns/1ps
module tb_top;
	import irq_pkg::*;
	logic clk, resetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready;
	logic rvalid, rready, comparator_out, slow_tick, cpu_boundary, cpu_call, cpu_ret, cpu_return_from_interrupt;
	logic cpu_sleep, vector_jump, resume, wake_up, stack_full, slow, call_req, ret_req, sleep_req;
	logic [ADDR_W-1:0] awaddr, araddr;
	logic [31:0] wdata, rdata, rd, m;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, rs, ext_irq_pins;
	logic [6:0] ev;
	logic [PC_W-1:0] cpu_next_pc, jump_addr, resume_addr, saved_pc;
	int mismatches = 0, samples_checked = 0, jumps = 0, rets = 0, wakes = 0, cyc = 0;
	int seed, flags, en, g0, g1, g2, jseen, rseen, w0, p0, p1, t1n, per0, per1;

	irq_controller dut_u (.clk, .resetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
		.wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
		.rready, .ext_irq_pins, .comparator_out, .conversion_done(ev[6]), .timer0_amatch(ev[5]),
		.timer0_pmatch(ev[4]), .timer1_amatch(ev[3]), .timer1_pmatch(ev[2]),
		.eeprom_write_end(ev[1]), .low_voltage_detect(ev[0]), .slow_tick, .cpu_boundary,
		.cpu_next_pc, .cpu_call, .cpu_ret, .cpu_return_from_interrupt, .cpu_sleep, .vector_jump, .jump_addr,
		.resume, .resume_addr, .wake_up, .stack_full);
	cpu_seq cpu_u (.clk, .resetn, .slow, .call_req, .ret_req, .sleep_req, .vector_jump,
		.cpu_boundary, .cpu_next_pc, .cpu_call, .cpu_ret, .cpu_return_from_interrupt, .cpu_sleep, .saved_pc);

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// pulses are counted here so a wait never misses a one-cycle answer
	always @(posedge clk) begin
		cyc <= cyc + 1;
		// slow source ticks every other cycle, so it is told apart from the system clock
		slow_tick <= cyc[0];
		jumps <= jumps + int'(vector_jump === 1'b1);
		rets <= rets + int'(resume === 1'b1);
		wakes <= wakes + int'(wake_up === 1'b1);
	end

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic results();
		if (mismatches == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	function automatic logic sig(input int w);
		case (w)
			0: return awready;
			1: return bvalid;
			2: return arready;
			3: return rvalid;
			4: return jumps > jseen;
			default: return rets > rseen;
		endcase
	endfunction
	task automatic await(input int w, input int lim);
		int n;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (sig(w) !== 1'b1 && n < lim);
		if (sig(w) !== 1'b1) begin
			mismatches++;
			results();
		end
		jseen += int'(w == 4);
		rseen += int'(w == 5);
	endtask
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		{awvalid, wvalid} <= 2'b11;
		await(0, 50);
		@(posedge clk);
		{awvalid, wvalid, bready} <= 3'b001;
		await(1, 50);
		rs = bresp;
		@(posedge clk);
		bready <= 1'b0;
	endtask
	task automatic rd_reg(input logic [ADDR_W-1:0] a);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		await(2, 50);
		@(posedge clk);
		{arvalid, rready} <= 2'b01;
		await(3, 50);
		rd = rdata;
		rs = rresp;
		@(posedge clk);
		rready <= 1'b0;
	endtask
	// a group flag rises only when one of its members goes from low to high
	task automatic fire(input logic [6:0] v);
		@(posedge clk);
		ev <= v;
		@(posedge clk);
		ev <= 7'h0;
		flags |= int'(v[6]) << SRC_ADC;
		flags |= int'(|(v[5:4] & ~g0[1:0])) << SRC_GRP0;
		flags |= int'(|(v[3:2] & ~g1[1:0])) << SRC_GRP1;
		flags |= int'(|(v[1:0] & ~g2[1:0])) << SRC_GRP2;
		g0 |= v[5:4];
		g1 |= v[3:2];
		g2 |= v[1:0];
	endtask
	task automatic cpu_req(input int k);
		@(posedge clk);
		{call_req, ret_req} <= (k == 0) ? 2'b10 : 2'b01;
		@(posedge clk);
		{call_req, ret_req} <= 2'b00;
	endtask
	task automatic do_ret();
		cpu_req(1);
		await(5, 50);
		check("resume address", resume_addr, saved_pc);
	endtask
	task automatic take(input int lim);
		int i;
		await(4, lim);
		for (i = 0; i < NSRC && !(flags[i] & en[i]); i++);
		check("vector", jump_addr, VEC_BASE + VEC_STEP * PC_W'(i));
		flags &= ~(1 << i);
	endtask

	initial begin
		seed = 32'hf6bbe22b;
		{resetn, awvalid, wvalid, bready, arvalid, rready, comparator_out, ev} = '0;
		{slow, call_req, ret_req, sleep_req, ext_irq_pins, awaddr, araddr, wdata} = '0;
		wstrb = 4'hf;
		{flags, g0, g1, g2, jseen, rseen, t1n} = '0;
		per0 = int'(TB0_BASE) << 3;
		per1 = int'(TB1_BASE) << 2;
		repeat (16) @(posedge clk);
		resetn <= 1'b1;
		rd_reg(GRP1_OFS);
		check("timer1 group reset", rd, 32'h0);
		check("mapped read resp", rs, RESP_OKAY);
		rd_reg(GRP2_OFS);
		check("eeprom group reset", rd, 32'h0);
		rd_reg(TBC_OFS);
		check("timebase control reset", rd, {24'h0, TBC_RESET & TBC_RD_MASK});
		rd_reg(8'h20);
		check("unmapped read data", rd, 32'h0);
		check("unmapped read resp", rs, RESP_SLVERR);
		wr(8'h20, 32'hffffffff);
		check("unmapped write resp", rs, RESP_SLVERR);
		wr(GRP1_OFS, 32'hffffffff);
		check("mapped write resp", rs, RESP_OKAY);
		wr(GRP2_OFS, 32'hffffffff);
		rd_reg(GRP1_OFS);
		check("timer1 group layout", rd, 32'h33);
		rd_reg(GRP2_OFS);
		check("eeprom group layout", rd, 32'h33);
		rd_reg(FLAG_OFS);
		check("group flags from members", rd, (3 << SRC_GRP1) << 1);
		wr(GRP1_OFS, 32'h0);
		wr(GRP2_OFS, 32'h0);
		wr(EN_OFS, 1 << (SRC_EXT0 + 1) | 1 << (SRC_EXT1 + 1));
		for (int c = 0; c < 4; c++) begin
			wr(EDGE_OFS, c * 5);
			for (int e = 0; e < 2; e++) begin
				wr(FLAG_OFS, 32'h0);
				ext_irq_pins <= (e == 0) ? 2'b11 : 2'b00;
				comparator_out <= ~comparator_out;
				repeat (8) @(posedge clk);
				rd_reg(FLAG_OFS);
				check("pin flags", rd, (c[e] ? 32'h102 : 32'h0) | 32'h4);
			end
		end
		flags = 32'h83;
		for (int i = 0; i < 5; i++) begin
			m = (i == 4) ? 32'h7f : $random(seed);
			fire(m[6:0]);
			rd_reg(FLAG_OFS);
			check("event flags", rd, flags << 1);
		end
		check("no take with global off", jumps, 0);
		en = 32'h1ff;
		wr(EN_OFS, 32'h3ff);
		while (flags != 0) begin
			take(100);
			rd_reg(EN_OFS);
			check("global enable after take", rd[0], 1'b0);
			rd_reg(FLAG_OFS);
			check("flags after service", rd, flags << 1);
			do_ret();
			wr(EN_OFS, 32'h3ff);
		end
		rd_reg(GRP2_OFS);
		check("members kept", rd, g2 << 4);
		slow <= 1'b1;
		en = 1 << SRC_ADC;
		wr(EN_OFS, 1 | en << 1);
		repeat (STACK_DEPTH) cpu_req(0);
		comparator_out <= ~comparator_out;
		fire(7'h40);
		flags |= 1 << SRC_COMP;
		@(negedge clk);
		check("stack full", stack_full, 1'b1);
		repeat (20) @(posedge clk);
		check("no take on full stack", jumps, jseen);
		rd_reg(FLAG_OFS);
		check("flags held", rd, flags << 1);
		rd_reg(STAT_OFS);
		check("status", rd, 32'h108 | STACK_DEPTH);
		do_ret();
		take(100);
		repeat (STACK_DEPTH) do_ret();
		sleep_req <= 1'b1;
		repeat (3) @(posedge clk);
		w0 = wakes;
		fire(7'h40);
		repeat (3) @(posedge clk);
		check("wake on new flag", wakes, w0 + 1);
		fire(7'h40);
		repeat (3) @(posedge clk);
		check("no wake on set flag", wakes, w0 + 1);
		sleep_req <= 1'b0;
		slow <= 1'b0;
		wr(FLAG_OFS, 32'h0);
		wr(TBC_OFS, 32'h92);
		wr(EN_OFS, 1 | 1 << (SRC_TB0 + 1) | 1 << (SRC_TB1 + 1));
		p0 = -1;
		p1 = -1;
		// the first overflow may wait for a divider wrap, so the bound is wide
		for (int k = 0; k < 24 && t1n < 2; k++) begin
			await(4, 40000);
			if (jump_addr === VEC_BASE + VEC_STEP * PC_W'(SRC_TB0)) begin
				if (p0 >= 0)
					check("tb0 period", cyc - p0 > per0 - 32 && cyc - p0 < per0 + 32, 1);
				p0 = cyc;
			end else begin
				check("tb1 vector", jump_addr, VEC_BASE + VEC_STEP * PC_W'(SRC_TB1));
				if (p1 >= 0)
					check("tb1 period", cyc - p1 > per1 - 32 && cyc - p1 < per1 + 32, 1);
				p1 = cyc;
				t1n++;
			end
			do_ret();
			wr(EN_OFS, 1 | 1 << (SRC_TB0 + 1) | 1 << (SRC_TB1 + 1));
		end
		check("tb1 overflows seen", t1n, 2);
		// clock select 1: one tick every fourth system clock, shortest period
		wr(EN_OFS, 32'h0);
		wr(TBC_OFS, 32'hc0);
		wr(FLAG_OFS, 32'h0);
		per0 = int'(TB0_BASE) << 2;
		p0 = -1;
		for (int k = 0; k < 2; k++) begin
			wr(EN_OFS, 1 | 1 << (SRC_TB0 + 1));
			await(4, 3000);
			check("tb0 sys vector", jump_addr, VEC_BASE + VEC_STEP * PC_W'(SRC_TB0));
			if (p0 >= 0)
				check("tb0 sys period", cyc - p0 > per0 - 32 && cyc - p0 < per0 + 32, 1);
			p0 = cyc;
			do_ret();
		end
		results();
	end
endmodule
